// ==== logic/slpc_lane_chk.sv ====
`timescale 1ns/10ps
module slpc_lane_chk (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // control
  input  wire slpc_pkg::slpc_cfg_t cfg,
  input  wire logic              en,
  input  wire logic              active,
  // received bit, already synchronised
  input  wire logic              rx_bit,
  // result
  output logic [23:0]            err_cnt,
  output logic                   pass
);

  function automatic logic [4:0] pat_order(input logic [1:0] p);
    case (p)
      slpc_pkg::PAT_PRBS7:  pat_order = slpc_pkg::ORD_PRBS7;
      slpc_pkg::PAT_PRBS15: pat_order = slpc_pkg::ORD_PRBS15;
      default:              pat_order = slpc_pkg::ORD_PRBS31;
    endcase
  endfunction

  slpc_pkg::slpc_lane_t s_r;
  slpc_pkg::slpc_lane_t s_nxt;
  logic                 pred;

  // ----------------------------------------
  // self-synchronising checker
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    case (cfg.pat) // R5
      slpc_pkg::PAT_PRBS7:  pred = s_r.sh[6] ^ s_r.sh[5];
      slpc_pkg::PAT_PRBS15: pred = s_r.sh[14] ^ s_r.sh[13];
      default:              pred = s_r.sh[30] ^ s_r.sh[27];
    endcase
    if (cfg.clr) begin
      s_nxt = '0; // R7
    end else if (en && active) begin // R3 R6
      s_nxt.sh = {s_r.sh[29:0], rx_bit};
      // first bits only seed the predictor
      if (s_r.fill < pat_order(cfg.pat)) begin
        s_nxt.fill = s_r.fill + 5'h01;
      end else if (rx_bit != pred && s_r.cnt != slpc_pkg::CNT_MAX) begin
        s_nxt.cnt = s_r.cnt + 24'h000001; // R12
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign err_cnt = s_r.cnt;
  assign pass    = (s_r.cnt <= cfg.thr); // R12

endmodule

// ==== logic/slpc_pkg.sv ====
package slpc_pkg;

  // ----------------------------------------
  // register indices, byte address = 4 * index
  // ----------------------------------------
  localparam logic [9:0] IDX_SYNC_CFG = 10'h312;
  localparam logic [9:0] IDX_LANE_EN  = 10'h315;
  localparam logic [9:0] IDX_CTRL     = 10'h316;
  localparam logic [9:0] IDX_THR_LO   = 10'h317;
  localparam logic [9:0] IDX_THR_MID  = 10'h318;
  localparam logic [9:0] IDX_THR_HI   = 10'h319;
  localparam logic [9:0] IDX_CNT_LO   = 10'h31a;
  localparam logic [9:0] IDX_CNT_MID  = 10'h31b;
  localparam logic [9:0] IDX_CNT_HI   = 10'h31c;
  localparam logic [9:0] IDX_PASS     = 10'h31d;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int         CTL_SEL_LSB  = 4;
  localparam int         CTL_PAT_LSB  = 2;
  localparam int         CTL_RUN_BIT  = 1;
  localparam int         CTL_CLR_BIT  = 0;
  localparam int         SYNC_LEN_LSB = 4;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] RST_PASS     = 8'hff;
  localparam logic [7:0] CTL_RW_MASK  = 8'h7f;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  localparam logic [23:0] CNT_MAX     = 24'hffffff;

  // ----------------------------------------
  // patterns, orders and test states
  // ----------------------------------------
  localparam logic [1:0] PAT_PRBS7    = 2'h0;
  localparam logic [1:0] PAT_PRBS15   = 2'h1;
  localparam logic [1:0] PAT_PRBS31   = 2'h2;
  localparam logic [4:0] ORD_PRBS7    = 5'h07;
  localparam logic [4:0] ORD_PRBS15   = 5'h0f;
  localparam logic [4:0] ORD_PRBS31   = 5'h1f;

  typedef enum logic [1:0] {
    BT_IDLE = 2'h0,
    BT_RUN  = 2'h1,
    BT_HOLD = 2'h3
  } slpc_bt_t;

  // ----------------------------------------
  // carriers and state records
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  lane_en;
    logic        run;
    logic        clr;
    logic [1:0]  pat;
    logic [23:0] thr;
  } slpc_cfg_t;

  typedef struct packed {
    logic [30:0] sh;
    logic [4:0]  fill;
    logic [23:0] cnt;
  } slpc_lane_t;

  typedef struct packed {
    logic [4:0] left;
    logic       req_n;
  } slpc_sync_t;

endpackage

// ==== logic/slpc_sync_pulse.sv ====
`timescale 1ns/10ps
module slpc_sync_pulse (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // request and length
  input  wire logic       err_evt,
  input  wire logic [3:0] len,
  // line, low while reporting
  output logic            req_n
);

  slpc_pkg::slpc_sync_t s_r;
  slpc_pkg::slpc_sync_t s_nxt;

  // ----------------------------------------
  // one clk is half a processing cycle
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (s_r.left != 5'h00) begin
      s_nxt.left = s_r.left - 5'h01;
      s_nxt.req_n = (s_r.left == 5'h01);
    end else if (err_evt) begin
      // events during a pulse merge into it
      s_nxt.left = {len, 1'b1}; // R1
      s_nxt.req_n = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '{left: 5'h00, req_n: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign req_n = s_r.req_n;

endmodule

// ==== logic/slpc_top.sv ====
// Operation
// R1 - sync request held low (0.5 + code) processing cycles per error report
// R2 - one length setting serves both sync request outputs
// R3 - lane checkers idle unless their enable bit is set
// R4 - 3-bit selector picks which lane count is reported
// R5 - pattern select 00 PRBS7, 01 PRBS15, 10 PRBS31, 11 unused
// R6 - checking and counting only while run bit is one
// R7 - clear bit holds state machine and counters in reset
// R8 - threshold low byte at 0x317, middle byte at 0x318
// R9 - threshold upper byte at 0x319
// R10 - selected count readable as three bytes, low byte first
// R11 - per-lane pass flags read-only, reset to all ones
// R12 - saturating 24-bit mismatch count, fail when above threshold
`timescale 1ns/10ps
module slpc_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial lanes, one bit per clock each
  input  wire logic [7:0]  lane_serial_in,
  // sync error events from link logic
  input  wire logic        link0_sync_error,
  input  wire logic        link1_sync_error,
  // sync request lines, active low
  output logic             link0_sync_request_out_n,
  output logic             link1_sync_request_out_n
);

  // ----------------------------------------
  // state record
  // ----------------------------------------
  typedef struct packed {
    logic             aw_hold;
    logic [9:0]       aw_idx;
    logic             aw_bad;
    logic             w_hold;
    logic [7:0]       w_byte;
    logic             w_lane0;
    logic             awrdy;
    logic             wrdy;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arrdy;
    logic             rvalid;
    logic [7:0]       rdata;
    logic [1:0]       rresp;
    logic [7:0]       lane_en;
    logic [7:0]       ctrl;
    logic [23:0]      thr;
    logic [7:0]       sync_cfg;
    slpc_pkg::slpc_bt_t bt;
    logic [7:0]       rx_meta;
    logic [7:0]       rx_sync;
  } slpc_top_t;

  slpc_top_t            s_r;
  slpc_top_t            s_nxt;
  slpc_pkg::slpc_cfg_t  cfg;
  logic [23:0]          lane_cnt [8];
  logic [7:0]           lane_pass;
  logic [23:0]          sel_cnt;
  logic                 bt_active;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [9:0] reg_idx(input logic [11:0] a);
    reg_idx = a[11:2];
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    logic [9:0] i;
    i = reg_idx(a);
    is_mapped = 1'b0;
    if (a[1:0] == 2'h0) begin
      case (i)
        slpc_pkg::IDX_SYNC_CFG,
        slpc_pkg::IDX_LANE_EN,
        slpc_pkg::IDX_CTRL,
        slpc_pkg::IDX_THR_LO,
        slpc_pkg::IDX_THR_MID,
        slpc_pkg::IDX_THR_HI,
        slpc_pkg::IDX_CNT_LO,
        slpc_pkg::IDX_CNT_MID,
        slpc_pkg::IDX_CNT_HI,
        slpc_pkg::IDX_PASS: begin
          is_mapped = 1'b1;
        end
        default: begin
          is_mapped = 1'b0;
        end
      endcase
    end
  endfunction

  // ----------------------------------------
  // configuration seen by the lanes
  // ----------------------------------------
  always_comb begin
    cfg.lane_en = s_r.lane_en;
    cfg.run     = s_r.ctrl[slpc_pkg::CTL_RUN_BIT];
    cfg.clr     = s_r.ctrl[slpc_pkg::CTL_CLR_BIT];
    cfg.pat     = s_r.ctrl[slpc_pkg::CTL_PAT_LSB +: 2];
    cfg.thr     = s_r.thr; // R8 R9
  end

  assign bt_active = (s_r.bt == slpc_pkg::BT_RUN);

  // ----------------------------------------
  // lane checkers
  // ----------------------------------------
  for (genvar g = 0; g < 8; g++) begin : g_lane
    slpc_lane_chk u_chk (
      .clk     (clk),
      .sys_rst (sys_rst),
      .cfg     (cfg),
      .en      (s_r.lane_en[g]), // R3
      .active  (bt_active),
      .rx_bit  (s_r.rx_sync[g]),
      .err_cnt (lane_cnt[g]),
      .pass    (lane_pass[g])
    );
  end

  assign sel_cnt = lane_cnt[s_r.ctrl[slpc_pkg::CTL_SEL_LSB +: 3]]; // R4

  // ----------------------------------------
  // sync request pulse generators
  // ----------------------------------------
  // both share one length field
  slpc_sync_pulse u_sync0 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .err_evt (link0_sync_error),
    .len     (s_r.sync_cfg[slpc_pkg::SYNC_LEN_LSB +: 4]), // R2
    .req_n   (link0_sync_request_out_n)
  );

  slpc_sync_pulse u_sync1 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .err_evt (link1_sync_error),
    .len     (s_r.sync_cfg[slpc_pkg::SYNC_LEN_LSB +: 4]), // R2
    .req_n   (link1_sync_request_out_n)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;

    // lane pins cross in through two flops
    s_nxt.rx_meta = lane_serial_in;
    s_nxt.rx_sync = s_r.rx_meta;

    // test state machine
    case (s_r.bt)
      slpc_pkg::BT_IDLE: begin
        if (cfg.run) begin
          s_nxt.bt = slpc_pkg::BT_RUN; // R6
        end
      end
      slpc_pkg::BT_RUN: begin
        if (!cfg.run) begin
          s_nxt.bt = slpc_pkg::BT_HOLD; // R6
        end
      end
      slpc_pkg::BT_HOLD: begin
        if (cfg.run) begin
          s_nxt.bt = slpc_pkg::BT_RUN;
        end
      end
      default: begin
        s_nxt.bt = slpc_pkg::BT_IDLE;
      end
    endcase
    if (cfg.clr) begin
      s_nxt.bt = slpc_pkg::BT_IDLE; // R7
    end

    // write address and data, either order
    if (s_axi_awvalid && s_r.awrdy) begin
      s_nxt.aw_hold = 1'b1;
      s_nxt.aw_idx  = reg_idx(s_axi_awaddr);
      s_nxt.aw_bad  = !is_mapped(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_r.wrdy) begin
      s_nxt.w_hold  = 1'b1;
      s_nxt.w_byte  = s_axi_wdata[7:0];
      s_nxt.w_lane0 = s_axi_wstrb[0];
    end

    // response retires before the next write
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    if (s_r.aw_hold && s_r.w_hold && !s_r.bvalid) begin
      s_nxt.aw_hold = 1'b0;
      s_nxt.w_hold  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = s_r.aw_bad ? slpc_pkg::RESP_SLVERR : slpc_pkg::RESP_OKAY;
      if (!s_r.aw_bad && s_r.w_lane0) begin
        case (s_r.aw_idx)
          slpc_pkg::IDX_SYNC_CFG: begin
            s_nxt.sync_cfg = s_r.w_byte; // R1
          end
          slpc_pkg::IDX_LANE_EN: begin
            s_nxt.lane_en = s_r.w_byte; // R3
          end
          slpc_pkg::IDX_CTRL: begin
            s_nxt.ctrl = s_r.w_byte & slpc_pkg::CTL_RW_MASK;
          end
          slpc_pkg::IDX_THR_LO: begin
            s_nxt.thr[7:0] = s_r.w_byte; // R8
          end
          slpc_pkg::IDX_THR_MID: begin
            s_nxt.thr[15:8] = s_r.w_byte; // R8
          end
          slpc_pkg::IDX_THR_HI: begin
            s_nxt.thr[23:16] = s_r.w_byte; // R9
          end
          default: begin
            // read-only targets ignore writes
            s_nxt.thr = s_r.thr;
          end
        endcase
      end
    end

    s_nxt.awrdy = !s_nxt.aw_hold && !s_nxt.bvalid;
    s_nxt.wrdy  = !s_nxt.w_hold && !s_nxt.bvalid;

    // read channel, one outstanding
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arrdy) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = is_mapped(s_axi_araddr) ? slpc_pkg::RESP_OKAY : slpc_pkg::RESP_SLVERR;
      case (reg_idx(s_axi_araddr))
        slpc_pkg::IDX_SYNC_CFG: s_nxt.rdata = s_r.sync_cfg;
        slpc_pkg::IDX_LANE_EN:  s_nxt.rdata = s_r.lane_en;
        slpc_pkg::IDX_CTRL:     s_nxt.rdata = s_r.ctrl;
        slpc_pkg::IDX_THR_LO:   s_nxt.rdata = s_r.thr[7:0];
        slpc_pkg::IDX_THR_MID:  s_nxt.rdata = s_r.thr[15:8];
        slpc_pkg::IDX_THR_HI:   s_nxt.rdata = s_r.thr[23:16];
        slpc_pkg::IDX_CNT_LO:   s_nxt.rdata = sel_cnt[7:0];   // R10
        slpc_pkg::IDX_CNT_MID:  s_nxt.rdata = sel_cnt[15:8];  // R10
        slpc_pkg::IDX_CNT_HI:   s_nxt.rdata = sel_cnt[23:16]; // R10
        slpc_pkg::IDX_PASS:     s_nxt.rdata = lane_pass;      // R11
        default:                s_nxt.rdata = slpc_pkg::RST_BYTE;
      endcase
      if (s_axi_araddr[1:0] != 2'h0) begin
        s_nxt.rdata = slpc_pkg::RST_BYTE;
      end
    end
    s_nxt.arrdy = !s_nxt.rvalid;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r          <= '0;
      s_r.bt       <= slpc_pkg::BT_IDLE;
      s_r.awrdy    <= 1'b1;
      s_r.wrdy     <= 1'b1;
      s_r.arrdy    <= 1'b1;
      s_r.lane_en  <= slpc_pkg::RST_BYTE;
      s_r.ctrl     <= slpc_pkg::RST_BYTE;
      s_r.sync_cfg <= slpc_pkg::RST_BYTE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready = s_r.awrdy;
  assign s_axi_wready  = s_r.wrdy;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.arrdy;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rresp   = s_r.rresp;
  assign s_axi_rdata   = {24'h000000, s_r.rdata};

endmodule

// ==== verif/slpc_prbs_tx.sv ====
`timescale 1ns/10ps
module slpc_prbs_tx (
  // clock
  input wire logic       clk,
  // pattern and injected bit flips
  input wire logic [1:0] pat,
  input wire logic [7:0] flip,
  // serial lanes
  output logic [7:0]     lane_out
);
  logic [30:0] sh_r = 31'h00000001;
  logic        nb;

  always_comb begin
    case (pat)
      slpc_pkg::PAT_PRBS7:  nb = sh_r[6] ^ sh_r[5];
      slpc_pkg::PAT_PRBS15: nb = sh_r[14] ^ sh_r[13];
      default:              nb = sh_r[30] ^ sh_r[27];
    endcase
  end

  initial lane_out = 8'h00;
  // flips stay out of the generator so one flip costs three mismatches
  always @(posedge clk) begin
    sh_r     <= {sh_r[29:0], nb};
    lane_out <= {8{nb}} ^ flip;
  end
endmodule

// ==== verif/slpc_top_sva.sv ====
`timescale 1ns/10ps
module slpc_top_sva (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // register bus
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // sync events and requests
  input wire logic        link0_sync_error,
  input wire logic        link1_sync_error,
  input wire logic        link0_sync_request_out_n,
  input wire logic        link1_sync_request_out_n
);
  logic [3:0]  len_r;
  logic [4:0]  lo0_r;
  logic [4:0]  lo1_r;
  logic [11:0] ar_r;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  function automatic logic mapped(input logic [11:0] a);
    logic [9:0] i;
    i = a[11:2];
    return a[1:0] == 2'h0 && (i == slpc_pkg::IDX_SYNC_CFG ||
           (i >= slpc_pkg::IDX_LANE_EN && i <= slpc_pkg::IDX_PASS));
  endfunction

  // --------------------------------
  // shadow length and low-time counters
  // --------------------------------
  // length shadow assumes address and data arrive together
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      len_r <= 4'h0;
      lo0_r <= 5'h00;
      lo1_r <= 5'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0] &&
          s_axi_awaddr == {slpc_pkg::IDX_SYNC_CFG, 2'h0}) begin
        len_r <= s_axi_wdata[7:4];
      end
      lo0_r <= link0_sync_request_out_n ? 5'h00 : lo0_r + 5'h01;
      lo1_r <= link1_sync_request_out_n ? 5'h00 : lo1_r + 5'h01;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      ar_r <= s_axi_araddr;
    end
  end

  // --------------------------------
  // properties
  // --------------------------------
  sync0_cause_a: assert property ($fell(link0_sync_request_out_n) |-> $past(link0_sync_error))
    else $error("sync0 low without event");
  sync0_len_a: assert property ($rose(link0_sync_request_out_n) |-> lo0_r == {len_r, 1'b1})
    else $error("sync0 low time wrong");
  sync1_cause_a: assert property ($fell(link1_sync_request_out_n) |-> $past(link1_sync_error))
    else $error("sync1 low without event");
  sync1_len_a: assert property ($rose(link1_sync_request_out_n) |-> lo1_r == {len_r, 1'b1})
    else $error("sync1 low time wrong");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // both halves taken at one edge: held next edge, answered the edge after
  write_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  byte_wide_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  resp_map_a: assert property ($rose(s_axi_rvalid) |->
    s_axi_rresp == (mapped(ar_r) ? slpc_pkg::RESP_OKAY : slpc_pkg::RESP_SLVERR))
    else $error("read response code wrong");

  cover property ($rose(link0_sync_request_out_n));
  cover property ($rose(link1_sync_request_out_n));
  cover property (s_axi_rvalid && s_axi_rresp == slpc_pkg::RESP_SLVERR);
endmodule

bind slpc_top slpc_top_sva i_slpc_top_sva (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .link0_sync_error, .link1_sync_error, .link0_sync_request_out_n, .link1_sync_request_out_n);

// ==== verif/slpc_top_tb_top.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (b)); end end
module slpc_top_tb_top;
  // --------------------------------
  // signals
  // --------------------------------
  logic        clk     = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] awaddr  = 12'h000;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h00000000;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic [11:0] araddr  = 12'h000;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        ev0     = 1'b0;
  logic        ev1     = 1'b0;
  logic [1:0]  pat     = 2'h0;
  logic [7:0]  flip    = 8'h00;
  logic [7:0]  lane;
  logic        awready;
  logic        wready;
  logic        bvalid;
  logic        arready;
  logic        rvalid;
  logic        q0_n;
  logic        q1_n;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [1:0]  r;
  logic [23:0] e;
  logic [3:0]  ln;
  int          error_cnt = 0;
  int          checked   = 0;

  slpc_top i_slpc_top (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lane_serial_in(lane),
    .link0_sync_error(ev0), .link1_sync_error(ev1), .link0_sync_request_out_n(q0_n),
    .link1_sync_request_out_n(q1_n));
  slpc_prbs_tx i_slpc_prbs_tx (.clk(clk), .pat(pat), .flip(flip), .lane_out(lane));

  initial begin
    forever #10 clk = ~clk;
  end

  // --------------------------------
  // bus tasks
  // --------------------------------
  task automatic wr(input logic [9:0] i, input logic [7:0] v);
    logic a;
    logic w;
    a = 1'b1;
    w = 1'b1;
    @(posedge clk);
    awaddr  <= {i, 2'h0};
    wdata   <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (a || w) begin
      @(posedge clk);
      if (a && awready) begin a = 1'b0; awvalid <= 1'b0; end
      if (w && wready) begin w = 1'b0; wvalid <= 1'b0; end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    bready <= 1'b1;
    @(posedge clk);
    `CHK(bresp, slpc_pkg::RESP_OKAY)
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] i);
    @(posedge clk);
    araddr  <= {i, 2'h0};
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b1;
    @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [9:0] i, input logic [7:0] v);
    rd(i);
    `CHK(d, {24'h000000, v})
    `CHK(r, slpc_pkg::RESP_OKAY)
  endtask

  task automatic hit(input logic [7:0] m);
    @(posedge clk);
    flip <= m;
    @(posedge clk);
    flip <= 8'h00;
    repeat (40) @(posedge clk);
  endtask

  // low samples over a window longer than the longest pulse
  task automatic pulse(input logic k, input logic [3:0] len);
    int n;
    n = 0;
    @(posedge clk);
    ev0 <= !k;
    ev1 <= k;
    @(posedge clk);
    ev0 <= 1'b0;
    ev1 <= 1'b0;
    repeat (40) begin
      @(posedge clk);
      if ((k ? q1_n : q0_n) === 1'b0) n++;
    end
    `CHK(n, 2 * len + 1)
  endtask

  task automatic print_verdict();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end

  // --------------------------------
  // tests
  // --------------------------------
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    for (logic [9:0] i = 10'h312; i <= 10'h31d; i++) begin
      rd(i);
      `CHK(d, {24'h000000, i == slpc_pkg::IDX_PASS ? 8'hff : 8'h00})
      `CHK(r, (i == 10'h313 || i == 10'h314) ? slpc_pkg::RESP_SLVERR : slpc_pkg::RESP_OKAY)
    end
    $display("test reset values done");
    wr(slpc_pkg::IDX_CTRL, 8'hff);
    rchk(slpc_pkg::IDX_CTRL, 8'h7f);
    wr(slpc_pkg::IDX_CNT_LO, 8'h5a);
    rchk(slpc_pkg::IDX_CNT_LO, 8'h00);
    wr(slpc_pkg::IDX_THR_MID, 8'h3c);
    rchk(slpc_pkg::IDX_THR_MID, 8'h3c);
    wr(slpc_pkg::IDX_THR_HI, 8'hc3);
    rchk(slpc_pkg::IDX_THR_HI, 8'hc3);
    $display("test register access done");
    for (int k = 0; k < 3; k++) begin
      ln = 4'(k * 7 + k / 2);
      wr(slpc_pkg::IDX_SYNC_CFG, {ln, 4'h0});
      pulse(1'b0, ln);
      pulse(1'b1, ln);
    end
    $display("test sync pulse done");
    wr(slpc_pkg::IDX_THR_LO, 8'h03);
    wr(slpc_pkg::IDX_THR_MID, 8'h00);
    wr(slpc_pkg::IDX_THR_HI, 8'h00);
    // lanes 0-3 enabled, one flip on all, second on lane 1
    for (int p = 0; p < 3; p++) begin
      pat <= 2'(p);
      wr(slpc_pkg::IDX_CTRL, {4'h0, 2'(p), 2'b01});
      wr(slpc_pkg::IDX_LANE_EN, 8'h0f);
      wr(slpc_pkg::IDX_CTRL, {4'h0, 2'(p), 2'b10});
      repeat (40) @(posedge clk);
      hit(8'hff);
      hit(8'h02);
      for (int s = 0; s < 8; s++) begin
        wr(slpc_pkg::IDX_CTRL, {1'b0, 3'(s), 2'(p), 2'b10});
        e = s == 1 ? 24'h000006 : s < 4 ? 24'h000003 : 24'h000000;
        rchk(slpc_pkg::IDX_CNT_LO, e[7:0]);
        rchk(slpc_pkg::IDX_CNT_MID, e[15:8]);
        rchk(slpc_pkg::IDX_CNT_HI, e[23:16]);
      end
      rchk(slpc_pkg::IDX_PASS, 8'hfd);
      wr(slpc_pkg::IDX_CTRL, {4'h0, 2'(p), 2'b00});
      hit(8'h01);
      rchk(slpc_pkg::IDX_CNT_LO, 8'h03);
      wr(slpc_pkg::IDX_CTRL, {4'h0, 2'(p), 2'b01});
      rchk(slpc_pkg::IDX_CNT_LO, 8'h00);
      rchk(slpc_pkg::IDX_PASS, 8'hff);
      $display("test pattern %0d done", p);
    end
    // reset while the clear bit is set must bring control back to its reset value
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rchk(slpc_pkg::IDX_CTRL, 8'h00);
    rchk(slpc_pkg::IDX_PASS, 8'hff);
    $display("test second reset done");
    print_verdict();
  end
endmodule
